/* rtl/analog_channel_data_formatter.sv */
// Purpose: Per-channel formatting between converter counts and controller data words.
// Assumes: Converter and controller logic share clk_i; config words arrive with cfg_wr_i.
// Notes: Input path accepts at most one sample every two cycles.
`timescale 1ns/100ps
module analog_channel_data_formatter import fmt_pkg::*; #(
	parameter int NCH = NCH_DEF,
	parameter int CH_W = CH_W_DEF,
	parameter int DAC_BITS = DAC_BITS_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_fmt_int_i,
	input wire logic signed [15:0] cfg_sig_lo_i,
	input wire logic signed [15:0] cfg_sig_hi_i,
	input wire logic signed [31:0] cfg_eng_lo_i,
	input wire logic signed [31:0] cfg_eng_hi_i,
	input wire logic signed [15:0] cfg_clamp_lo_i,
	input wire logic signed [15:0] cfg_clamp_hi_i,
	input wire logic signed [15:0] cfg_prog_val_i,
	input wire logic signed [15:0] cfg_alm_lo_i,
	input wire logic signed [15:0] cfg_alm_hi_i,
	input wire logic cfg_latch_en_i,
	input wire logic cal_wr_i,
	input wire logic cal_all_i,
	input wire logic [CH_W-1:0] cal_chan_i,
	input wire logic signed [15:0] cal_offset_i,
	input wire logic [NCH-1:0] alarm_clr_i,
	input wire logic inhibit_i,
	input wire logic adc_valid_i,
	input wire logic [CH_W-1:0] adc_chan_i,
	input wire logic [ADC_BITS-1:0] adc_code_i,
	output logic adc_ready_o,
	output logic up_valid_o,
	input wire logic up_ready_i,
	output logic [CH_W-1:0] up_chan_o,
	output logic [31:0] up_data_o,
	input wire logic dn_valid_i,
	input wire logic [CH_W-1:0] dn_chan_i,
	input wire logic [31:0] dn_data_i,
	output logic dn_ready_o,
	output logic dac_valid_o,
	output logic [CH_W-1:0] dac_chan_o,
	output logic [DAC_BITS-1:0] dac_code_o,
	output logic program_mode_o,
	output logic scale_ready_o,
	output logic fmt_float_o,
	output logic [NCH-1:0] alarm_lo_o,
	output logic [NCH-1:0] alarm_hi_o
);
	logic rst_meta_reg, rst_n_reg;
	logic fmt_float_reg, latch_en_reg, cfg_seen_reg;
	logic signed [15:0] sig_lo_reg, sig_hi_reg, clamp_lo_reg, clamp_hi_reg, prog_val_reg, alm_lo_reg, alm_hi_reg;
	logic signed [31:0] eng_lo_reg, eng_hi_reg, gain_reg, inv_reg;
	logic signed [15:0] off_reg [NCH];
	div_state_t div_state_reg;
	logic [DVS_W:0] rem_reg, rem_shift;
	logic [DVD_W-1:0] dvd_reg, quo_reg;
	logic [DVS_W-1:0] dvs_reg;
	logic [5:0] step_reg;
	logic neg_reg, scale_ready_reg, q_bit;
	logic [31:0] q_mag;
	logic signed [31:0] q_res;
	logic signed [32:0] d_eng, d_sig;
	logic adc_ready_reg, s1_valid_reg, s1_valid_next, adc_take, push;
	logic [CH_W-1:0] s1_chan_reg;
	logic signed [15:0] s1_x_reg, in_x;
	logic signed [16:0] in_diff;
	logic signed [48:0] in_prod;
	logic signed [49:0] in_eng;
	logic signed [31:0] in_fix;
	logic [31:0] in_word;
	logic [NCH-1:0] alarm_lo_reg, alarm_hi_reg;
	logic dn_ready_reg, dn_take, dac_valid_reg, prog_mode_reg;
	logic [CH_W-1:0] dac_chan_reg, sweep_reg;
	logic [DAC_BITS-1:0] dac_code_reg, prog_code;
	logic signed [31:0] dn_fix;
	logic signed [32:0] out_diff;
	logic signed [65:0] out_prod, out_cnt;
	logic signed [15:0] out_v;
	logic [15:0] out_ob;
	fifo_if #(.W(CH_W+32)) fq ();
	// Fraction bits of the two slopes; gain saturates above 128 units per count
	localparam int GAIN_FRAC = 8;
	localparam int INV_FRAC = 24;

	////////////////////////////////////////////////////////////////////////////////
	// Saturate a wide signed value to a signed 16-bit count
	function automatic logic signed [15:0] sat16(input logic signed [65:0] v);
		if (v > 66'(CNT_MAX)) return CNT_MAX;
		if (v < 66'(CNT_MIN)) return CNT_MIN;
		return v[15:0];
	endfunction : sat16

	// Q16.16 fixed point to IEEE single precision, truncating
	function automatic logic [31:0] fix_to_float(input logic signed [31:0] v);
		logic [31:0] mag;
		logic [7:0] e;
		logic [22:0] m;
		int p;
		mag = v[31] ? 32'(-v) : 32'(v);
		p = -1;
		for (int i = 0; i < 32; i++) begin
			if (mag[i]) p = i;
		end
		if (p < 0) return 32'h0000_0000;
		e = 8'(p + EXP_BIAS - FRAC_BITS);
		if (p >= 23) m = 23'(mag >> (p - 23));
		else m = 23'(mag << (23 - p));
		return {v[31], e, m};
	endfunction : fix_to_float

	// IEEE single precision to Q16.16, saturating at the fixed-point limits
	function automatic logic signed [31:0] float_to_fix(input logic [31:0] f);
		logic [7:0] e;
		logic [55:0] m;
		int sh;
		e = f[30:23];
		m = {32'h0000_0000, 1'b1, f[22:0]};
		if (e < EXP_MIN) return 32'sh0000_0000;
		if (e > EXP_MAX) return f[31] ? FIX_MIN : FIX_MAX;
		sh = int'(e) - EXP_SHIFT0;
		if (sh >= 0) m = m << sh;
		else m = m >> (-sh);
		return f[31] ? -$signed(m[31:0]) : $signed(m[31:0]);
	endfunction : float_to_fix

	////////////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// Configuration capture; format comes up as floating point
	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			fmt_float_reg <= FMT_FLOAT_RST;
			cfg_seen_reg <= 1'b0;
			latch_en_reg <= 1'b0;
			{sig_lo_reg, sig_hi_reg, clamp_lo_reg, clamp_hi_reg} <= '0;
			{prog_val_reg, alm_lo_reg, alm_hi_reg} <= '0;
			{eng_lo_reg, eng_hi_reg} <= '0;
		end else if (cfg_wr_i) begin
			fmt_float_reg <= !cfg_fmt_int_i;
			cfg_seen_reg <= 1'b1;
			latch_en_reg <= cfg_latch_en_i;
			sig_lo_reg <= cfg_sig_lo_i;
			sig_hi_reg <= cfg_sig_hi_i;
			clamp_lo_reg <= cfg_clamp_lo_i;
			clamp_hi_reg <= cfg_clamp_hi_i;
			prog_val_reg <= cfg_prog_val_i;
			alm_lo_reg <= cfg_alm_lo_i;
			alm_hi_reg <= cfg_alm_hi_i;
			eng_lo_reg <= cfg_eng_lo_i;
			eng_hi_reg <= cfg_eng_hi_i;
		end
	end

	// Sensor offsets, written per channel or for the whole module
	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int c = 0; c < NCH; c++) off_reg[c] <= 16'sh0000;
		end else if (cal_wr_i) begin
			for (int c = 0; c < NCH; c++) begin
				if (cal_all_i || (CH_W'(c) == cal_chan_i)) off_reg[c] <= cal_offset_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Restoring divider step and signed, saturated quotient
	assign rem_shift = {rem_reg[DVS_W-1:0], dvd_reg[DVD_W-1]};
	assign q_bit = (rem_shift >= {1'b0, dvs_reg});
	assign q_mag = (quo_reg[DVD_W-2:31] != '0) ? 32'(FIX_MAX) : quo_reg[31:0];
	assign q_res = (dvs_reg == '0) ? 32'sh0000_0000 : (neg_reg ? -$signed(q_mag) : $signed(q_mag));
	assign d_eng = 33'(eng_hi_reg) - 33'(eng_lo_reg);
	assign d_sig = 33'(sig_hi_reg) - 33'(sig_lo_reg);

	// Slope in both directions from the two scaling points
	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			div_state_reg <= DIV_IDLE;
			{rem_reg, dvd_reg, dvs_reg, quo_reg, step_reg, neg_reg} <= '0;
			gain_reg <= '0;
			inv_reg <= '0;
			scale_ready_reg <= 1'b1;
		end else if (cfg_wr_i) begin
			div_state_reg <= DIV_GAIN;
			scale_ready_reg <= 1'b0;
			step_reg <= '0;
			rem_reg <= '0;
			quo_reg <= '0;
			neg_reg <= 1'b0;
			dvd_reg <= '0;
			dvs_reg <= '0;
		end else begin
			unique case (div_state_reg)
				DIV_IDLE: begin
					scale_ready_reg <= 1'b1;
				end
				DIV_GAIN, DIV_INV: begin
					if (step_reg == 6'd0 && div_state_reg == DIV_GAIN && quo_reg == '0 && dvs_reg == '0 && !neg_reg) begin
						// Load engineering span over signal span
						dvd_reg <= {16'h0000, (d_eng[32] ? 33'(-d_eng) : 33'(d_eng))} << GAIN_FRAC;
						dvs_reg <= d_sig[32] ? 33'(-d_sig) : 33'(d_sig);
						neg_reg <= d_eng[32] ^ d_sig[32];
						quo_reg <= '1;
					end else begin
						rem_reg <= q_bit ? (rem_shift - {1'b0, dvs_reg}) : rem_shift;
						quo_reg <= {quo_reg[DVD_W-2:0], q_bit};
						dvd_reg <= {dvd_reg[DVD_W-2:0], 1'b0};
						step_reg <= step_reg + 6'd1;
					end
					if (step_reg == 6'(DIV_STEPS)) begin
						step_reg <= '0;
						rem_reg <= '0;
						quo_reg <= '0;
						if (div_state_reg == DIV_GAIN) begin
							gain_reg <= q_res;
							div_state_reg <= DIV_INV;
							// Load signal span over engineering span
							dvd_reg <= {16'h0000, (d_sig[32] ? 33'(-d_sig) : 33'(d_sig))} << INV_FRAC;
							dvs_reg <= d_eng[32] ? 33'(-d_eng) : 33'(d_eng);
							neg_reg <= d_eng[32] ^ d_sig[32];
						end else begin
							inv_reg <= q_res;
							div_state_reg <= DIV_IDLE;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input path: offset binary code to signed count, plus sensor offset
	assign adc_take = adc_valid_i && adc_ready_reg;
	assign in_x = sat16(66'($signed(adc_code_i ^ OFFSET_BIN)) + 66'(off_reg[adc_chan_i]));
	assign push = s1_valid_reg && fq.wr_ready;
	assign s1_valid_next = adc_take || (s1_valid_reg && !push);

	// Linear scaling, unlimited beyond the scaling points, and word format
	always_comb begin
		in_diff = 17'(s1_x_reg) - 17'(sig_lo_reg);
		in_prod = 49'(in_diff) * 49'(gain_reg);
		in_eng = 50'(in_prod >>> GAIN_FRAC) + 50'(eng_lo_reg);
		if (in_eng > 50'(FIX_MAX)) in_fix = FIX_MAX;
		else if (in_eng < 50'(FIX_MIN)) in_fix = FIX_MIN;
		else in_fix = in_eng[31:0];
		if (fmt_float_reg) in_word = fix_to_float(in_fix);
		else in_word = {{16{s1_x_reg[15]}}, s1_x_reg};
	end

	assign fq.wr_valid = s1_valid_reg;
	assign fq.wr_data = {s1_chan_reg, in_word};
	assign fq.rd_ready = up_ready_i;
	assign up_valid_o = fq.rd_valid;
	assign up_chan_o = fq.rd_data[CH_W+31:32];
	assign up_data_o = fq.rd_data[31:0];

	// Sample stage; ready waits for the stage to drain and the slopes to settle
	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			s1_valid_reg <= 1'b0;
			s1_chan_reg <= '0;
			s1_x_reg <= '0;
			adc_ready_reg <= 1'b0;
		end else begin
			s1_valid_reg <= s1_valid_next;
			adc_ready_reg <= !s1_valid_next && scale_ready_reg && !cfg_wr_i;
			if (adc_take) begin
				s1_chan_reg <= adc_chan_i;
				s1_x_reg <= in_x;
			end
		end
	end

	// Alarms; a new trip wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			alarm_lo_reg <= '0;
			alarm_hi_reg <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (adc_take && adc_chan_i == CH_W'(c) && !latch_en_reg) begin
					alarm_lo_reg[c] <= (in_x < alm_lo_reg);
					alarm_hi_reg[c] <= (in_x > alm_hi_reg);
				end else begin
					alarm_lo_reg[c] <= (alarm_lo_reg[c] && !alarm_clr_i[c]) ||
						(adc_take && adc_chan_i == CH_W'(c) && in_x < alm_lo_reg);
					alarm_hi_reg[c] <= (alarm_hi_reg[c] && !alarm_clr_i[c]) ||
						(adc_take && adc_chan_i == CH_W'(c) && in_x > alm_hi_reg);
				end
			end
		end
	end

	sample_fifo #(.WIDTH(CH_W+32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_ni(rst_n_reg),
		.q(fq.fifo)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output path: inverse scaling, offset, clamp in float only, converter width
	assign dn_take = dn_valid_i && dn_ready_reg;
	assign prog_code = DAC_BITS'(16'(prog_val_reg ^ OFFSET_BIN) >> (16 - DAC_BITS));
	always_comb begin
		dn_fix = float_to_fix(dn_data_i);
		out_diff = 33'(dn_fix) - 33'(eng_lo_reg);
		out_prod = 66'(out_diff) * 66'(inv_reg);
		out_cnt = (out_prod >>> INV_FRAC) + 66'(sig_lo_reg);
		if (fmt_float_reg) begin
			out_v = sat16(out_cnt + 66'(off_reg[dn_chan_i]));
			if (out_v < clamp_lo_reg) out_v = clamp_lo_reg;
			else if (out_v > clamp_hi_reg) out_v = clamp_hi_reg;
		end else begin
			out_v = sat16(66'($signed(dn_data_i[15:0])) + 66'(off_reg[dn_chan_i]));
		end
		out_ob = out_v ^ OFFSET_BIN;
	end

	// Converter writes; inhibit sweeps every channel to the program value
	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			dn_ready_reg <= 1'b0;
			dac_valid_reg <= 1'b0;
			dac_chan_reg <= '0;
			dac_code_reg <= '0;
			prog_mode_reg <= 1'b0;
			sweep_reg <= '0;
		end else begin
			dn_ready_reg <= !inhibit_i && scale_ready_reg && !cfg_wr_i;
			prog_mode_reg <= inhibit_i;
			if (inhibit_i) begin
				dac_valid_reg <= 1'b1;
				dac_chan_reg <= sweep_reg;
				dac_code_reg <= prog_code;
				sweep_reg <= (sweep_reg == CH_W'(NCH - 1)) ? '0 : sweep_reg + CH_W'(1);
			end else begin
				dac_valid_reg <= dn_take;
				sweep_reg <= '0;
				if (dn_take) begin
					dac_chan_reg <= dn_chan_i;
					dac_code_reg <= out_ob[15 -: DAC_BITS];
				end
			end
		end
	end

	assign adc_ready_o = adc_ready_reg;
	assign dn_ready_o = dn_ready_reg;
	assign dac_valid_o = dac_valid_reg;
	assign dac_chan_o = dac_chan_reg;
	assign dac_code_o = dac_code_reg;
	assign program_mode_o = prog_mode_reg;
	assign scale_ready_o = scale_ready_reg;
	assign fmt_float_o = fmt_float_reg;
	assign alarm_lo_o = alarm_lo_reg;
	assign alarm_hi_o = alarm_hi_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the design's own behaviour
	localparam int SCALE_WAIT = 2 * DIV_STEPS + 8;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_reg);

	alarm_latch_a: assert property (latch_en_reg |=>
		(($past(alarm_lo_reg) & ~$past(alarm_clr_i) & ~alarm_lo_o) == '0) &&
		(($past(alarm_hi_reg) & ~$past(alarm_clr_i) & ~alarm_hi_o) == '0))
		else $error("latched alarm dropped");
	int_word_a: assert property (push && !fmt_float_reg |-> fq.wr_data[31:16] == {16{fq.wr_data[15]}})
		else $error("integer word not sign extended");
	fmt_default_a: assert property (!cfg_seen_reg |-> fmt_float_o)
		else $error("format not float before configuration");
	int_noscale_a: assert property (push && !fmt_float_reg |-> fq.wr_data[15:0] == s1_x_reg)
		else $error("integer sample altered");
	int_noclamp_a: assert property (dn_take && !inhibit_i && !fmt_float_reg && off_reg[dn_chan_i] == 16'sh0000 |=>
		dac_code_o == DAC_BITS'({~$past(dn_data_i[15]), $past(dn_data_i[14:0])} >> (16 - DAC_BITS)))
		else $error("integer output clamped");
	prog_value_a: assert property (inhibit_i[*3] |-> dac_valid_o && dac_code_o == prog_code && program_mode_o)
		else $error("inhibited output not at program value");
	prog_sweep_a: assert property ($rose(inhibit_i) |-> ##[1:2] (dac_valid_o && program_mode_o))
		else $error("program mode not entered");
	no_dn_inhibit_a: assert property (inhibit_i |=> !dn_ready_o)
		else $error("ready while inhibited");
	code_ends_a: assert property (adc_take && adc_code_i == 16'h0000 && off_reg[adc_chan_i] == 16'sh0000 |=>
		s1_x_reg == CNT_MIN)
		else $error("low end not most negative code");
	count_sat_a: assert property (adc_take && adc_code_i == 16'hffff && !off_reg[adc_chan_i][15] |=>
		s1_x_reg == CNT_MAX)
		else $error("count wrapped");
	cal_all_a: assert property (cal_wr_i && cal_all_i |=> off_reg[0] == $past(cal_offset_i) &&
		off_reg[NCH-1] == $past(cal_offset_i))
		else $error("module-wide calibration missed a channel");
	scale_done_a: assert property (cfg_wr_i ##1 !cfg_wr_i [*8] |-> ##[0:SCALE_WAIT] scale_ready_o)
		else $error("slope computation did not finish");

	float_push_c: cover property (push && fmt_float_reg);
	int_push_c: cover property (push && !fmt_float_reg);
	inhibit_c: cover property (inhibit_i [*4] ##1 !inhibit_i);
	latched_alarm_c: cover property (latch_en_reg && alarm_hi_o[0] ##3 alarm_hi_o[0]);
endmodule : analog_channel_data_formatter

/* rtl/fifo_if.sv */
// Purpose: Valid/ready carrier between the formatter and its sample FIFO.
// Assumes: Both sides run on one clock.
// Notes: A word moves on a cycle where valid and ready are both high.
`timescale 1ns/100ps
interface fifo_if #(parameter int W = 8) ();
	logic wr_valid;
	logic wr_ready;
	logic [W-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [W-1:0] rd_data;
	modport fifo (input wr_valid, input wr_data, input rd_ready, output wr_ready, output rd_valid, output rd_data);
	modport user (output wr_valid, output wr_data, output rd_ready, input wr_ready, input rd_valid, input rd_data);
endinterface : fifo_if

/* rtl/fmt_pkg.sv */
// Purpose: Shared constants and types for the analog channel data formatter.
// Assumes: Signed counts are 16-bit two's complement; engineering values are Q16.16 fixed point.
// Notes: Divider widths cover a 33-bit difference shifted by the fraction width.
//
// Overview of operation
// - Latched alarms stay set after condition clears
// - Integer format exchanges signed 16-bit words
// - Float format exchanges IEEE single, all features
// - Format resets to floating point
// - Scaling only in float; integer passes counts
// - Integer output format never clamps
// - Inhibit forces program mode, outputs to program value
// - Input samples resolve to 16 bits
// - Output converter width 13 to 16 bits
// - One count equals range over code total
// - Resolution independent of format and scaling
// - Two points map linearly to engineering values
// - Beyond scaling points extrapolate linearly
// - Sensor offset added to input or output
// - Calibrate one channel or all at once
// - Range ends map to most negative/positive codes
package fmt_pkg;
	localparam int ADC_BITS = 16;
	localparam int CODE_COUNT = 65536;
	localparam int DAC_BITS_DEF = 16;
	localparam int NCH_DEF = 8;
	localparam int CH_W_DEF = 3;
	localparam int FIFO_DEPTH_DEF = 8;
	localparam int FRAC_BITS = 16;
	localparam logic [15:0] OFFSET_BIN = 16'h8000;
	localparam logic signed [15:0] CNT_MAX = 16'sh7fff;
	localparam logic signed [15:0] CNT_MIN = 16'sh8000;
	localparam logic signed [31:0] FIX_MAX = 32'sh7fff_ffff;
	localparam logic signed [31:0] FIX_MIN = 32'sh8000_0000;
	localparam logic FMT_FLOAT_RST = 1'b1;
	localparam logic [7:0] EXP_MIN = 8'h6f;
	localparam logic [7:0] EXP_MAX = 8'h8d;
	localparam int EXP_SHIFT0 = 134;
	localparam int EXP_BIAS = 127;
	localparam int DVD_W = 49;
	localparam int DVS_W = 33;
	localparam int DIV_STEPS = 49;
	typedef enum logic [1:0] {DIV_IDLE, DIV_GAIN, DIV_INV} div_state_t;
endpackage : fmt_pkg

/* rtl/sample_fifo.sv */
// Purpose: Sample FIFO with registered write-ready and registered read data.
// Assumes: DEPTH is a power of two.
// Notes: Holds DEPTH words in memory plus one in the output register.
`timescale 1ns/100ps
module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_ni,
	fifo_if.fifo q
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic wr_ready_reg;
	logic out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////////////
	// Handshake terms and occupancy
	assign push = q.wr_valid && wr_ready_reg;
	assign pop = (count_reg != '0) && (!out_valid_reg || q.rd_ready);
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign q.wr_ready = wr_ready_reg;
	assign q.rd_valid = out_valid_reg;
	assign q.rd_data = out_data_reg;

	// Storage, no reset needed on data
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= q.wr_data;
		end
	end

	// Pointers, count and honest full flag
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			wr_ready_reg <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg <= count_next;
			wr_ready_reg <= (count_next != (AW+1)'(DEPTH));
		end
	end

	// Output register stage
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end else if (pop) begin
			out_valid_reg <= 1'b1;
			out_data_reg <= mem_reg[rd_ptr_reg];
		end else if (q.rd_ready) begin
			out_valid_reg <= 1'b0;
		end
	end
endmodule : sample_fifo

/* tb/analog_channel_data_formatter_tb.sv */
// Purpose: Self-checking bench for the channel data formatter.
// Assumes: Q16.16 engineering values, one sample stream, one output stream.
// Notes: Expected words are worked out by hand from the scaling set below.
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module analog_channel_data_formatter_tb;
	logic clk_i, nrst_i, cfg_wr, fmt_int, cal_wr, cal_all, inhibit, adc_valid, up_ready, dn_valid, stall, latch;
	logic adc_ready, up_valid, dn_ready, dac_valid, pmode, sready, ffloat;
	logic [2:0] cal_chan, adc_chan, dn_chan, up_chan, dac_chan;
	logic [15:0] adc_code, cal_off, dac_code;
	logic [15:0] slo = 16'h0000, shi = 16'h0064, clo = 16'h8000, chi = 16'h0096, alo = 16'hfc18, ahi = 16'h03e8;
	logic [15:0] prog = 16'h04d2;
	logic [31:0] up_data, dn_data, elo = 32'h000a_0000, ehi = 32'h006e_0000;
	logic [7:0] alm_clr, alarm_lo, alarm_hi;
	logic [34:0] w;
	int n_errors, compares, i;
	analog_channel_data_formatter dut (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_wr_i(cfg_wr), .cfg_fmt_int_i(fmt_int),
		.cfg_sig_lo_i(slo), .cfg_sig_hi_i(shi), .cfg_eng_lo_i(elo), .cfg_eng_hi_i(ehi), .cfg_clamp_lo_i(clo),
		.cfg_clamp_hi_i(chi), .cfg_prog_val_i(prog), .cfg_alm_lo_i(alo), .cfg_alm_hi_i(ahi), .cfg_latch_en_i(latch),
		.cal_wr_i(cal_wr), .cal_all_i(cal_all), .cal_chan_i(cal_chan), .cal_offset_i(cal_off), .alarm_clr_i(alm_clr),
		.inhibit_i(inhibit), .adc_valid_i(adc_valid), .adc_chan_i(adc_chan), .adc_code_i(adc_code),
		.adc_ready_o(adc_ready), .up_valid_o(up_valid), .up_ready_i(up_ready), .up_chan_o(up_chan),
		.up_data_o(up_data), .dn_valid_i(dn_valid), .dn_chan_i(dn_chan), .dn_data_i(dn_data), .dn_ready_o(dn_ready),
		.dac_valid_o(dac_valid), .dac_chan_o(dac_chan), .dac_code_o(dac_code), .program_mode_o(pmode),
		.scale_ready_o(sready), .fmt_float_o(ffloat), .alarm_lo_o(alarm_lo), .alarm_hi_o(alarm_hi));
	ctl_model p (.clk_i(clk_i), .nrst_i(nrst_i), .stall_i(stall), .up_valid_i(up_valid), .up_chan_i(up_chan),
		.up_data_i(up_data), .up_ready_o(up_ready));
	// Clock at 25 MHz
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task report_and_stop;
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Writes a config word and waits for the slopes to settle
	task cfg(input logic fi, input logic le);
		int k;
		@(posedge clk_i);
		fmt_int <= fi;
		latch <= le;
		cfg_wr <= 1'b1;
		@(posedge clk_i);
		cfg_wr <= 1'b0;
		k = 0;
		do begin @(posedge clk_i); k++; end while (sready !== 1'b1 && k < 500);
		if (k >= 500) n_errors++;
	endtask : cfg
	task cal(input logic a, input logic [2:0] c, input logic [15:0] o);
		@(posedge clk_i);
		cal_wr <= 1'b1;
		cal_all <= a;
		cal_chan <= c;
		cal_off <= o;
		@(posedge clk_i);
		cal_wr <= 1'b0;
	endtask : cal
	// Holds the sample until the edge where ready is seen high
	task send_adc(input logic [2:0] c, input logic [15:0] d);
		int k;
		@(posedge clk_i);
		adc_valid <= 1'b1;
		adc_chan <= c;
		adc_code <= d;
		k = 0;
		do begin @(posedge clk_i); k++; end while (adc_ready !== 1'b1 && k < 500);
		if (k >= 500) n_errors++;
		adc_valid <= 1'b0;
	endtask : send_adc
	task get_up(input logic [34:0] e);
		int k;
		k = 0;
		while (p.rx_q.size() == 0 && k < 500) begin @(posedge clk_i); k++; end
		w = (p.rx_q.size() > 0) ? p.rx_q.pop_front() : 'x;
		`CHK(w, e)
	endtask : get_up
	task chk_in(input logic [2:0] c, input logic [15:0] d, input logic [31:0] e);
		send_adc(c, d);
		get_up({c, e});
	endtask : chk_in
	// Output write; the converter strobe must follow one edge after the take
	task chk_dn(input logic [2:0] c, input logic [31:0] d, input logic [15:0] e);
		int k;
		@(posedge clk_i);
		dn_valid <= 1'b1;
		dn_chan <= c;
		dn_data <= d;
		k = 0;
		do begin @(posedge clk_i); k++; end while (dn_ready !== 1'b1 && k < 500);
		if (k >= 500) n_errors++;
		dn_valid <= 1'b0;
		@(posedge clk_i);
		`CHK({dac_valid, dac_chan, dac_code}, {1'b1, c, e})
	endtask : chk_dn
	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		report_and_stop();
	end
	initial begin
		{nrst_i, cfg_wr, fmt_int, cal_wr, cal_all, inhibit, adc_valid, dn_valid, stall, latch} = '0;
		{cal_chan, adc_chan, dn_chan, adc_code, cal_off, dn_data, alm_clr} = '0;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		`CHK({ffloat, sready}, 2'b11)
		cfg(1'b0, 1'b0);
		`CHK(ffloat, 1'b1)
		chk_in(3'd1, 16'h8000, 32'h4120_0000);
		chk_in(3'd1, 16'h80c8, 32'h4352_0000);
		// Unlatched alarm follows the latest sample of its channel
		chk_in(3'd1, 16'h87d0, 32'h44fb_4000);
		`CHK(alarm_hi[1], 1'b1)
		chk_in(3'd1, 16'h8000, 32'h4120_0000);
		`CHK(alarm_hi[1], 1'b0)
		chk_dn(3'd0, 32'h4120_0000, 16'h8000);
		chk_dn(3'd0, 32'h4352_0000, 16'h8096);
		cfg(1'b1, 1'b1);
		`CHK(ffloat, 1'b0)
		chk_in(3'd1, 16'h0000, 32'hffff_8000);
		chk_in(3'd1, 16'hffff, 32'h0000_7fff);
		chk_in(3'd1, 16'h80c8, 32'h0000_00c8);
		chk_dn(3'd0, 32'h0000_00c8, 16'h80c8);
		cal(1'b1, 3'd0, 16'h0005);
		chk_in(3'd2, 16'hffff, 32'h0000_7fff);
		chk_in(3'd1, 16'h8064, 32'h0000_0069);
		chk_dn(3'd0, 32'h0000_7ffe, 16'hffff);
		cal(1'b0, 3'd2, 16'hfffd);
		chk_in(3'd2, 16'h8064, 32'h0000_0061);
		chk_in(3'd1, 16'h8064, 32'h0000_0069);
		// Latched high alarm survives a normal sample, then clears
		chk_in(3'd3, 16'h87d0, 32'h0000_07d5);
		chk_in(3'd3, 16'h8000, 32'h0000_0005);
		`CHK({alarm_hi[3], alarm_lo[3]}, 2'b10)
		@(posedge clk_i);
		alm_clr <= 8'h08;
		@(posedge clk_i);
		alm_clr <= 8'h00;
		@(posedge clk_i);
		`CHK(alarm_hi[3], 1'b0)
		// Stalled consumer fills the buffer, then all words drain in order
		stall <= 1'b1;
		fork
			for (i = 0; i < 12; i++) send_adc(3'd0, 16'h8000 + 16'(i));
			begin
				repeat (150) @(posedge clk_i);
				`CHK(adc_ready, 1'b0)
				stall <= 1'b0;
			end
		join
		for (i = 0; i < 12; i++) get_up({3'd0, 32'(i + 5)});
		// Inhibit sweeps every channel to the program value while output ready stays low
		@(posedge clk_i);
		inhibit <= 1'b1;
		@(posedge clk_i);
		for (i = 0; i < 8; i++) begin
			@(posedge clk_i);
			`CHK({pmode, dn_ready, dac_valid, dac_chan, dac_code}, {3'b101, 3'(i), 16'h84d2})
		end
		inhibit <= 1'b0;
		chk_dn(3'd4, 32'h0000_0010, 16'h8015);
		report_and_stop();
	end
endmodule : analog_channel_data_formatter_tb

/* tb/ctl_model.sv */
// Purpose: Controller-side consumer of the upstream sample stream.
// Assumes: One clock; stall_i holds off acceptance.
// Notes: Words are kept as {chan, data} in arrival order.
`timescale 1ns/100ps
module ctl_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic stall_i,
	input wire logic up_valid_i,
	input wire logic [2:0] up_chan_i,
	input wire logic [31:0] up_data_i,
	output logic up_ready_o
);
	logic [34:0] rx_q[$];
	// Ready follows the stall request one edge later; words taken on valid and ready
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			up_ready_o <= 1'b0;
		end else begin
			up_ready_o <= !stall_i;
			if (up_valid_i && up_ready_o) begin
				rx_q.push_back({up_chan_i, up_data_i});
			end
		end
	end
endmodule : ctl_model
